// ===== hdl/dcp_consts.vh
// constants for the ddr2 pin-side controller core
// assumes one system clock running at the doubled data rate
//
// Summary of operation
// [RULE_01] memory-side rate is the doubled-rate input clock divided by two
// [RULE_02] command, write and read queues run on the bus-side rate
// [RULE_03] sequencing state machine runs on the memory-side rate
// [RULE_04] bus-side and memory-side rates may be stopped by a proper procedure
// [RULE_05] external data bus is at most thirty-two bits wide
// [RULE_06] thirteen-bit address output plus three-bit bank address output
// [RULE_07] exactly one chip select and one clock enable toward memory
// [RULE_08] a differential pair of memory clock outputs is driven
// [RULE_09] clock enable is active high; low disables the memory clock
// [RULE_10] chip select goes low when the memory is to take a command
// [RULE_11] row, column and write strobes are active low and encode commands
// [RULE_12] per-byte masks qualify write data; a set bit blocks that lane
// [RULE_13] per-byte strobes active high, driven on writes, received on reads
// [RULE_14] bank address selects the bank the command applies to
// [RULE_15] data bus driven for writes, sampled for reads
// [RULE_16] memory clock pair runs at half the doubled-rate clock
// [RULE_17] traffic between queues and state machine crosses by handshake
`ifndef DCP_CONSTS_VH
`define DCP_CONSTS_VH

// ==========================================================
// pin widths
`define DCP_DQ_W 32
`define DCP_ADDR_W 13
`define DCP_BA_W 3
`define DCP_COL_W 10
`define DCP_A10 10

// ==========================================================
// queues
`define DCP_FIFO_D 4
`define DCP_FIFO_AW 2

// ==========================================================
// command codes {ras_n, cas_n, we_n}
`define DCP_CMD_NOP 3'h7
`define DCP_CMD_ACT 3'h3
`define DCP_CMD_RD 3'h5
`define DCP_CMD_WR 3'h4
`define DCP_CMD_PRE 3'h2

// ==========================================================
// timing in memory clock cycles
`define DCP_CNT_W 4
`define DCP_TRCD 4'h2
`define DCP_TRP 4'h2
`define DCP_CL 4'h3
`define DCP_WL 4'h2
`define DCP_RD_TMO 4'h2

`endif

// ===== hdl/dcp_fifo.v
// small synchronous queue, flip-flop storage
// push and pop are qualified inside by the caller's rate enable on ce
`default_nettype none

module dcp_fifo #(
    parameter W = 32,
    parameter D = 4,
    parameter AW = 2
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);

// ==========================================================
// storage and pointers
reg [W-1:0] mem_r [0:D-1];
reg [AW-1:0] wp_r;
reg [AW-1:0] rp_r;
reg [AW:0] cnt_r;
wire push;
wire pop;

assign in_ready = ce && (cnt_r != D[AW:0]);
assign out_valid = ce && (cnt_r != {(AW+1){1'b0}});
assign out_data = mem_r[rp_r];
assign push = in_valid && in_ready;
assign pop = out_valid && out_ready;

always @(posedge clk) begin
    if (push) begin
        mem_r[wp_r] <= in_data;
    end
end

// ==========================================================
// occupancy
always @(posedge clk or posedge rst) begin
    if (rst) begin
        wp_r <= {AW{1'b0}};
        rp_r <= {AW{1'b0}};
        cnt_r <= {(AW+1){1'b0}};
    end else begin
        if (push) begin
            wp_r <= (wp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
        end
        if (pop) begin
            rp_r <= (rp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
        end
        if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end
end

endmodule // dcp_fifo

`default_nettype wire

// ===== hdl/dcp_core.v
// ddr2 controller core: bus-side queues, memory sequencer and pin drivers
// assumes sys_clk is the doubled-rate clock and the pad ring resolves
// the two-way pins from the enables
`include "dcp_consts.vh"
`default_nettype none

module dcp_core #(
    parameter DQ_W = `DCP_DQ_W,
    parameter FIFO_D = `DCP_FIFO_D,
    parameter FIFO_AW = `DCP_FIFO_AW
) (
    input wire sys_clk,
    input wire rst,
    input wire bus_stop,
    input wire mem_stop_req,
    output wire mem_stop_ack,
    input wire cmd_valid,
    output wire cmd_ready,
    input wire cmd_write,
    input wire [`DCP_BA_W-1:0] cmd_bank,
    input wire [`DCP_ADDR_W-1:0] cmd_row,
    input wire [`DCP_COL_W-1:0] cmd_col,
    input wire wr_valid,
    output wire wr_ready,
    input wire [DQ_W-1:0] wr_data,
    input wire [DQ_W/8-1:0] wr_mask,
    output wire rd_valid,
    input wire rd_ready,
    output wire [DQ_W-1:0] rd_data,
    output wire mem_clk_p,
    output wire mem_clk_n,
    output wire mem_cke,
    output wire mem_cs_n,
    output wire mem_ras_n,
    output wire mem_cas_n,
    output wire mem_we_n,
    output wire [`DCP_BA_W-1:0] mem_ba,
    output wire [`DCP_ADDR_W-1:0] mem_addr,
    output wire [DQ_W/8-1:0] mem_dqm,
    input wire [DQ_W/8-1:0] mem_dqs_in,
    output wire [DQ_W/8-1:0] mem_dqs_out,
    output wire [DQ_W/8-1:0] mem_dqs_oe,
    input wire [DQ_W-1:0] mem_dq_in,
    output wire [DQ_W-1:0] mem_dq_out,
    output wire mem_dq_oe
);

localparam BL = DQ_W / 8;
localparam CW = 1 + `DCP_BA_W + `DCP_ADDR_W + `DCP_COL_W;
localparam WW = DQ_W + BL;

// ==========================================================
// sequencer states, one-hot
localparam S_IDLE = 7'h01;
localparam S_ACT = 7'h02;
localparam S_TRCD = 7'h04;
localparam S_CMD = 7'h08;
localparam S_LAT = 7'h10;
localparam S_XFER = 7'h20;
localparam S_PRE = 7'h40;

// ==========================================================
// rate enables
// single clock: the memory rate is a half-rate enable, not a new domain
reg mclk_r;
reg stopped_r;
wire mclk_en;
wire bus_en;

assign bus_en = !bus_stop; // see [RULE_02] see [RULE_04]
assign mclk_en = mclk_r && !stopped_r; // see [RULE_01] see [RULE_03]

always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        mclk_r <= 1'b0;
    end else if (!stopped_r) begin
        mclk_r <= !mclk_r; // see [RULE_16]
    end
end

// ==========================================================
// bus-side queues
wire cq_valid;
wire cq_ready;
wire [CW-1:0] cq_data;
wire wq_valid;
wire wq_ready;
wire [WW-1:0] wq_data;
wire rq_in_valid;
wire rq_in_ready;
reg [DQ_W-1:0] rq_in_data_r;

dcp_fifo #(
    .W(CW),
    .D(FIFO_D),
    .AW(FIFO_AW)
) u_cmd_q (
    .clk(sys_clk),
    .rst(rst),
    .ce(bus_en),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data({cmd_write, cmd_bank, cmd_row, cmd_col}),
    .out_valid(cq_valid),
    .out_ready(cq_ready),
    .out_data(cq_data)
); // see [RULE_02]

dcp_fifo #(
    .W(WW),
    .D(FIFO_D),
    .AW(FIFO_AW)
) u_wr_q (
    .clk(sys_clk),
    .rst(rst),
    .ce(bus_en),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data({wr_mask, wr_data}),
    .out_valid(wq_valid),
    .out_ready(wq_ready),
    .out_data(wq_data)
); // see [RULE_02]

dcp_fifo #(
    .W(DQ_W),
    .D(FIFO_D),
    .AW(FIFO_AW)
) u_rd_q (
    .clk(sys_clk),
    .rst(rst),
    .ce(bus_en),
    .in_valid(rq_in_valid),
    .in_ready(rq_in_ready),
    .in_data(rq_in_data_r),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
); // see [RULE_02]

// ==========================================================
// queue fields
wire q_write;
wire [`DCP_BA_W-1:0] q_bank;
wire [`DCP_ADDR_W-1:0] q_row;
wire [`DCP_COL_W-1:0] q_col;

assign q_col = cq_data[`DCP_COL_W-1:0];
assign q_row = cq_data[`DCP_COL_W+`DCP_ADDR_W-1:`DCP_COL_W];
assign q_bank = cq_data[CW-2:CW-1-`DCP_BA_W];
assign q_write = cq_data[CW-1];

// ==========================================================
// sequencer registers
reg [6:0] st_r;
reg [`DCP_CNT_W-1:0] cnt_r;
reg wr_op_r;
reg [`DCP_BA_W-1:0] ba_r;
reg [`DCP_COL_W-1:0] col_r;
reg [2:0] cmd_r;
reg cs_n_r;
reg cke_r;
reg [`DCP_ADDR_W-1:0] addr_r;
reg [`DCP_BA_W-1:0] ba_out_r;
reg [DQ_W-1:0] dq_out_r;
reg [BL-1:0] dqm_r;
reg [BL-1:0] wmask_r;
reg dq_oe_r;
reg rd_push_r;
wire start_ok;
wire rd_hit;
wire stop_go;

// a read waits for room so captured data is never dropped
assign start_ok = cq_valid && (q_write ? wq_valid : rq_in_ready); // see [RULE_17]
assign cq_ready = mclk_en && (st_r == S_IDLE) && !mem_stop_req && start_ok; // see [RULE_17]
assign wq_ready = mclk_en && (st_r == S_CMD) && wr_op_r; // see [RULE_17]
assign rq_in_valid = rd_push_r; // see [RULE_17]
assign rd_hit = (mem_dqs_in != {BL{1'b0}}) || (cnt_r == {`DCP_CNT_W{1'b0}});
assign stop_go = mclk_en && (st_r == S_IDLE) && mem_stop_req;

// ==========================================================
// stop procedure: only taken while idle, resumed when released
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        stopped_r <= 1'b0;
    end else if (stopped_r) begin
        stopped_r <= mem_stop_req;
    end else if (stop_go) begin
        stopped_r <= 1'b1; // see [RULE_04]
    end
end

assign mem_stop_ack = stopped_r;

// ==========================================================
// sequencer
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        st_r <= S_IDLE;
        cnt_r <= {`DCP_CNT_W{1'b0}};
        wr_op_r <= 1'b0;
        ba_r <= {`DCP_BA_W{1'b0}};
        col_r <= {`DCP_COL_W{1'b0}};
        cmd_r <= `DCP_CMD_NOP;
        cs_n_r <= 1'b1;
        cke_r <= 1'b0;
        addr_r <= {`DCP_ADDR_W{1'b0}};
        ba_out_r <= {`DCP_BA_W{1'b0}};
        dq_out_r <= {DQ_W{1'b0}};
        dqm_r <= {BL{1'b1}};
        dq_oe_r <= 1'b0;
        rd_push_r <= 1'b0;
        rq_in_data_r <= {DQ_W{1'b0}};
        wmask_r <= {BL{1'b1}};
    end else begin
        if (rd_push_r && rq_in_ready) begin
            rd_push_r <= 1'b0;
        end
        // cke drops on the entry edge so it is already low with the ack
        if (stopped_r || stop_go) begin
            cke_r <= 1'b0; // see [RULE_09]
        end else if (mclk_en) begin
            cke_r <= 1'b1; // see [RULE_09]
            cmd_r <= `DCP_CMD_NOP;
            cs_n_r <= 1'b1;
            case (st_r)
                S_IDLE: begin
                    if (cq_ready) begin
                        wr_op_r <= q_write;
                        ba_r <= q_bank;
                        col_r <= q_col;
                        cmd_r <= `DCP_CMD_ACT; // see [RULE_11]
                        cs_n_r <= 1'b0; // see [RULE_10]
                        addr_r <= q_row;
                        ba_out_r <= q_bank; // see [RULE_14]
                        cnt_r <= `DCP_TRCD;
                        st_r <= S_ACT;
                    end
                end
                S_ACT: begin
                    cnt_r <= cnt_r - 1'b1;
                    st_r <= S_TRCD;
                end
                S_TRCD: begin
                    if (cnt_r <= 4'h1) begin
                        cmd_r <= wr_op_r ? `DCP_CMD_WR : `DCP_CMD_RD; // see [RULE_11]
                        cs_n_r <= 1'b0; // see [RULE_10]
                        addr_r <= {{(`DCP_ADDR_W-`DCP_COL_W){1'b0}}, col_r};
                        ba_out_r <= ba_r; // see [RULE_14]
                        st_r <= S_CMD;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                S_CMD: begin
                    // a write waits for its word so a stopped bus side never loses it
                    if (wr_op_r && wq_valid) begin
                        dq_out_r <= wq_data[DQ_W-1:0];
                        wmask_r <= wq_data[WW-1:DQ_W]; // see [RULE_12]
                        cnt_r <= `DCP_WL;
                        st_r <= S_LAT;
                    end else if (!wr_op_r) begin
                        cnt_r <= `DCP_CL;
                        st_r <= S_LAT;
                    end
                end
                S_LAT: begin
                    cnt_r <= cnt_r - 1'b1;
                    if (cnt_r <= 4'h2) begin
                        dq_oe_r <= wr_op_r; // see [RULE_15]
                        // mask opens with the data, never ahead of it
                        dqm_r <= wr_op_r ? wmask_r : {BL{1'b1}}; // see [RULE_12]
                        cnt_r <= `DCP_RD_TMO;
                        st_r <= S_XFER;
                    end
                end
                S_XFER: begin
                    if (wr_op_r) begin
                        dq_oe_r <= 1'b0;
                        dqm_r <= {BL{1'b1}};
                        st_r <= S_PRE;
                    end else if (rd_hit) begin
                        rq_in_data_r <= mem_dq_in; // see [RULE_15]
                        rd_push_r <= 1'b1;
                        st_r <= S_PRE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                    if (st_r != S_XFER || wr_op_r || rd_hit) begin
                        cmd_r <= `DCP_CMD_PRE; // see [RULE_11]
                        cs_n_r <= 1'b0; // see [RULE_10]
                        addr_r <= {{(`DCP_ADDR_W-1){1'b0}}, 1'b1} << `DCP_A10;
                        cnt_r <= `DCP_TRP;
                    end
                end
                S_PRE: begin
                    if (cnt_r <= 4'h1) begin
                        st_r <= S_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                default: begin
                    st_r <= S_IDLE;
                end
            endcase
        end
    end
end

// ==========================================================
// pins
// memory clock pair: mclk_r is high when the enable fires, so the
// command launched on that edge is centred on the memory clock rise
assign mem_clk_p = mclk_r; // see [RULE_08] see [RULE_16]
assign mem_clk_n = !mclk_r; // see [RULE_08]
assign mem_cke = cke_r; // see [RULE_07] see [RULE_09]
assign mem_cs_n = cs_n_r; // see [RULE_07]
assign mem_ras_n = cmd_r[2];
assign mem_cas_n = cmd_r[1];
assign mem_we_n = cmd_r[0];
assign mem_ba = ba_out_r; // see [RULE_06]
assign mem_addr = addr_r; // see [RULE_06]
assign mem_dqm = dqm_r; // see [RULE_12]
assign mem_dq_out = dq_out_r; // see [RULE_05]
assign mem_dq_oe = dq_oe_r; // see [RULE_15]

// strobes follow the memory clock while write data is driven
genvar gi;
generate
    for (gi = 0; gi < BL; gi = gi + 1) begin : g_dqs
        assign mem_dqs_out[gi] = dq_oe_r & mclk_r; // see [RULE_13]
        assign mem_dqs_oe[gi] = dq_oe_r; // see [RULE_13]
    end
endgenerate

endmodule // dcp_core

`default_nettype wire

// ===== tb/dcp_mem_model.sv
// behavioural ddr2 memory for the pin side of dcp_core
// assumes commands hold two sys_clk and data rides one memory cycle
`include "dcp_consts.vh"
`default_nettype none
module dcp_mem_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [12:0] addr,
    input wire logic [3:0] dqm,
    input wire logic [31:0] dq_out,
    input wire logic dq_oe,
    output logic [3:0] dqs_in,
    output logic [31:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // storage and decode
    logic [31:0] mem [logic [25:0]];
    logic [3:0] cmd_q;
    logic [2:0] bank_r;
    logic [12:0] row_r;
    logic [25:0] wkey, rkey;
    logic [31:0] w;
    int cnt, hold;
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cmd_q <= 4'hf;
            cnt <= 0;
            hold <= 0;
            dqs_in <= 4'h0;
            dq_in <= 32'h0;
        end else begin
            cmd_q <= {cs_n, ras_n, cas_n, we_n};
            // a new command only when cs low and clock enabled
            if ({cs_n, ras_n, cas_n, we_n} != cmd_q && !cs_n && cke) begin
                case ({ras_n, cas_n, we_n})
                    `DCP_CMD_ACT: begin
                        bank_r <= ba;
                        row_r <= addr;
                    end
                    `DCP_CMD_WR: wkey <= {bank_r, row_r, addr[9:0]};
                    `DCP_CMD_RD: begin
                        rkey <= {bank_r, row_r, addr[9:0]};
                        cnt <= 2 * int'(`DCP_CL) + (slow ? 2 : 0);
                    end
                    default: ;
                endcase
            end
            // masked lanes keep old bytes
            if (dq_oe) begin
                w = mem.exists(wkey) ? mem[wkey] : 32'h0;
                for (int b = 0; b < 4; b++)
                    if (!dqm[b]) w[8*b +: 8] = dq_out[8*b +: 8];
                mem[wkey] = w;
            end
            if (cnt > 0) begin
                cnt <= cnt - 1;
                if (cnt == 1) hold <= 6;
            end
            // read burst with strobes high, else released lines wander
            if (hold > 0) begin
                hold <= hold - 1;
                dqs_in <= 4'hf;
                dq_in <= mem.exists(rkey) ? mem[rkey] : 32'h0;
            end else begin
                dqs_in <= 4'h0;
                dq_in <= ~dq_in;
            end
        end
    end
endmodule // dcp_mem_model
`default_nettype wire

// ===== tb/dcp_core_assertions.sv
// pin and queue checks for dcp_core
// assumes one sys_clk and active-high asynchronous rst
`include "dcp_consts.vh"
`default_nettype none
module dcp_core_assertions #(
    parameter DQ_W = 32
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic bus_stop,
    input wire logic mem_stop_ack,
    input wire logic cmd_ready,
    input wire logic wr_ready,
    input wire logic rd_valid,
    input wire logic mem_clk_p,
    input wire logic mem_clk_n,
    input wire logic mem_cke,
    input wire logic mem_cs_n,
    input wire logic mem_ras_n,
    input wire logic mem_cas_n,
    input wire logic mem_we_n,
    input wire logic [`DCP_ADDR_W-1:0] mem_addr,
    input wire logic [DQ_W/8-1:0] mem_dqm,
    input wire logic [DQ_W/8-1:0] mem_dqs_out,
    input wire logic [DQ_W/8-1:0] mem_dqs_oe,
    input wire logic mem_dq_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ==========================================
    // command decode
    wire logic [2:0] cmd = {mem_ras_n, mem_cas_n, mem_we_n};
    wire logic act = !mem_cs_n && cmd == `DCP_CMD_ACT;
    wire logic wr_c = !mem_cs_n && cmd == `DCP_CMD_WR;
    wire logic rd_c = !mem_cs_n && cmd == `DCP_CMD_RD;
    wire logic pre_c = !mem_cs_n && cmd == `DCP_CMD_PRE;
    a_clk_pair_inverse: assert property (
        mem_clk_n == !mem_clk_p) else $error("clock pair not inverse");
    a_clk_half_rate: assert property (
        !mem_stop_ack && !$past(mem_stop_ack) && !$past(rst) |-> mem_clk_p != $past(mem_clk_p))
        else $error("memory clock not toggling");
    a_stop_cke_low: assert property (
        mem_stop_ack |-> !mem_cke) else $error("cke high while stopped");
    a_stop_clk_frozen: assert property (
        mem_stop_ack && $past(mem_stop_ack) |-> $stable(mem_clk_p))
        else $error("clock moved while stopped");
    a_cmd_two_cycles: assert property (
        $changed({mem_cs_n, cmd}) && !$past(rst) |=> $stable({mem_cs_n, cmd}))
        else $error("command held one cycle only");
    a_act_to_access: assert property (
        act && !$past(act) |-> ##[3:5] (rd_c || wr_c)) else $error("no access after activate");
    a_wr_drives_data: assert property (
        wr_c && !$past(wr_c) |-> ##[3:6] mem_dq_oe) else $error("write data not driven");
    a_mask_write_only: assert property (
        !mem_dq_oe |-> mem_dqm == '1) else $error("mask open outside write");
    a_strobe_follow: assert property (
        mem_dqs_oe == {(DQ_W/8){mem_dq_oe}}
        && mem_dqs_out == (mem_dqs_oe & {(DQ_W/8){mem_clk_p}}))
        else $error("strobe not tied to write data");
    a_bus_stop_idle: assert property (
        bus_stop |-> !cmd_ready && !wr_ready && !rd_valid) else $error("queue live while stopped");
    a_pre_all_banks: assert property (
        pre_c |-> mem_addr[`DCP_A10]) else $error("precharge not all banks");
    a_rd_answer: assert property (
        rd_c && !$past(rd_c) |-> ##[6:14] rd_valid) else $error("read word never queued");
endmodule // dcp_core_assertions
bind dcp_core dcp_core_assertions #(.DQ_W(DQ_W)) u_chk (.sys_clk(sys_clk), .rst(rst),
    .bus_stop(bus_stop), .mem_stop_ack(mem_stop_ack), .cmd_ready(cmd_ready),
    .wr_ready(wr_ready), .rd_valid(rd_valid), .mem_clk_p(mem_clk_p), .mem_clk_n(mem_clk_n),
    .mem_cke(mem_cke), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
    .mem_we_n(mem_we_n), .mem_addr(mem_addr), .mem_dqm(mem_dqm), .mem_dqs_out(mem_dqs_out),
    .mem_dqs_oe(mem_dqs_oe), .mem_dq_oe(mem_dq_oe));
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for dcp_core with a behavioural memory
// assumes the checker is bound separately and sys_clk is 100 MHz
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // signals
    logic sys_clk = 0, rst = 1, bus_stop = 0, stop_req = 0, stop_ack, slow = 0;
    logic cmd_valid = 0, cmd_ready, cmd_write = 0, wr_valid = 0, wr_ready;
    logic rd_valid, rd_ready = 1, rd_stall = 0, clk_p, clk_n, cke, cs_n, ras_n, cas_n, we_n;
    logic [2:0] cmd_bank = 0, ba;
    logic [12:0] cmd_row = 0, addr;
    logic [9:0] cmd_col = 0;
    logic [31:0] wr_data = 0, rd_data, dq_in, dq_out, rnd = 32'h9f65acc4, srnd = 32'h9f65acc4;
    logic [3:0] wr_mask = 0, dqm, dqs_in, dqs_out, dqs_oe;
    logic dq_oe;
    logic [31:0] shadow [logic [25:0]];
    logic [31:0] exp_q[$];
    int fail_count = 0, total_checks = 0, n;
    always #5 sys_clk = ~sys_clk;
    dcp_core DUT (.sys_clk(sys_clk), .rst(rst), .bus_stop(bus_stop), .mem_stop_req(stop_req),
        .mem_stop_ack(stop_ack), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_write(cmd_write), .cmd_bank(cmd_bank), .cmd_row(cmd_row), .cmd_col(cmd_col),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .wr_mask(wr_mask),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .mem_clk_p(clk_p),
        .mem_clk_n(clk_n), .mem_cke(cke), .mem_cs_n(cs_n), .mem_ras_n(ras_n),
        .mem_cas_n(cas_n), .mem_we_n(we_n), .mem_ba(ba), .mem_addr(addr), .mem_dqm(dqm),
        .mem_dqs_in(dqs_in), .mem_dqs_out(dqs_out), .mem_dqs_oe(dqs_oe), .mem_dq_in(dq_in),
        .mem_dq_out(dq_out), .mem_dq_oe(dq_oe));
    dcp_mem_model u_mem (.sys_clk(sys_clk), .rst(rst), .slow(slow), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm),
        .dq_out(dq_out), .dq_oe(dq_oe), .dqs_in(dqs_in), .dq_in(dq_in));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic timeout(input string what);
        fail_count++;
        $display("BAD %s expected done seen timeout", what);
        end_sim();
    endtask
    // read side stalls at random, or fully while the read queue is filled
    always @(posedge sys_clk) begin
        srnd <= lfsr(srnd);
        rd_ready <= !rd_stall && srnd[3];
    end
    // oldest note against each word handed out
    always @(posedge sys_clk)
        if (!rst && rd_valid === 1'b1 && rd_ready === 1'b1) begin
            if (exp_q.size() == 0) chk("rd_extra", 32'h1, 32'h0);
            else chk("rd_data", rd_data, exp_q.pop_front());
        end
    // ==========================================
    // bus-side requests
    task automatic issue(input logic wr, input logic [25:0] k, input logic [31:0] d,
            input logic [3:0] m);
        logic c, wd;
        c = 1;
        wd = wr;
        @(posedge sys_clk);
        cmd_valid <= 1;
        cmd_write <= wr;
        {cmd_bank, cmd_row, cmd_col} <= k;
        wr_valid <= wr;
        wr_data <= d;
        wr_mask <= m;
        for (int i = 0; i < 200 && (c || wd); i++) begin
            @(posedge sys_clk);
            if (c && cmd_ready) begin c = 0; cmd_valid <= 0; end
            if (wd && wr_ready) begin wd = 0; wr_valid <= 0; end
        end
        if (c || wd) timeout("issue");
        if (wr) begin
            if (!shadow.exists(k)) shadow[k] = 32'h0;
            for (int b = 0; b < 4; b++) if (!m[b]) shadow[k][8*b +: 8] = d[8*b +: 8];
        end else exp_q.push_back(shadow.exists(k) ? shadow[k] : 32'h0);
    endtask
    task automatic drain;
        for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(posedge sys_clk);
        if (exp_q.size() > 0) timeout("drain");
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 0;
        // every bank, random rows, columns and data, random masks on the last eight
        for (int i = 0; i < 16; i++) begin
            rnd = lfsr(rnd);
            issue(1, {i[2:0], rnd[22:0]}, lfsr(rnd), i[3] ? rnd[27:24] : 4'h0);
            issue(0, {i[2:0], rnd[22:0]}, 32'h0, 4'h0);
        end
        drain();
        $display("test random access done");
        // slow strobes from the memory still land
        slow <= 1;
        issue(1, 26'h2aa_aaaa, 32'hc3a5_5a3c, 4'h0);
        issue(0, 26'h2aa_aaaa, 32'h0, 4'h0);
        drain();
        slow <= 0;
        $display("test slow strobes done");
        // bus stop holds off the queues
        bus_stop <= 1;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk("cmd_ready_stopped", {31'h0, cmd_ready}, 32'h0);
        @(posedge sys_clk);
        bus_stop <= 0;
        // memory stopped: queues fill to depth and refuse
        stop_req <= 1;
        for (n = 0; n < 100 && stop_ack !== 1'b1; n++) @(posedge sys_clk);
        if (stop_ack !== 1'b1) timeout("stop_ack");
        chk("cke_stopped", {31'h0, cke}, 32'h0);
        n = 0;
        @(posedge sys_clk);
        cmd_valid <= 1;
        cmd_write <= 1;
        {cmd_bank, cmd_row, cmd_col} <= 26'h155_5555;
        wr_valid <= 1;
        wr_data <= 32'h1234_5678;
        wr_mask <= 4'h0;
        repeat (12) begin
            @(posedge sys_clk);
            if (cmd_ready && wr_ready) n++;
        end
        cmd_valid <= 0;
        wr_valid <= 0;
        chk("queue_depth", n, 4);
        shadow[26'h155_5555] = 32'h1234_5678;
        rd_stall <= 1;
        stop_req <= 0;
        for (int i = 0; i < 4; i++) issue(0, 26'h155_5555, 32'h0, 4'h0);
        repeat (60) @(posedge sys_clk);
        chk("rd_full_valid", {31'h0, rd_valid}, 32'h1);
        rd_stall <= 0;
        drain();
        $display("test queue fill done");
        end_sim();
    end
    initial begin
        repeat (90000) @(posedge sys_clk);
        timeout("run");
    end
endmodule // tb
`default_nettype wire
